// [rtl/usr_pkg.sv]
package usr_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FLAG_W = 7;
  localparam int EP_COUNT = 4;
  localparam int FRAME_W = 11;
  localparam int FRAME_LO_W = 7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1 = 8'h05;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h06;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0D;
  localparam logic [7:0] OFS_BUF_SET = 8'h0E;
  localparam logic [7:0] OFS_ROLE = 8'h0F;
  localparam logic [7:0] OFS_FRAME_LO = 8'h15;
  localparam logic [7:0] OFS_FRAME_HI = 8'h16;
  localparam logic [7:0] OFS_DMA_CNT_LO = 8'h35;
  localparam logic [7:0] OFS_DMA_CNT_HI = 8'h36;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DMA_BUSY = 7;
  localparam int BIT_BUS_RESET = 6;
  localparam int BIT_FRAME_START = 5;
  localparam int BIT_DMA_DONE = 4;
  localparam int CTRL1_USB_EN = 0;
  localparam int CTRL1_DMA_EN = 1;
  localparam int CTRL1_DMA_DIR = 2;
  localparam int ROLE_MASTER = 7;
  localparam int ROLE_SWAP = 6;
  localparam int ENDPOINT_THREE = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] ROLE_RESET = 8'h00;
  localparam logic [7:0] DMA_CNT_RESET = 8'h00;
  localparam logic [7:0] FRAME_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  typedef enum logic [0:0] {
    USR_DMA_IDLE = 1'b0,
    USR_DMA_BUSY = 1'b1
  } usr_dma_state_type;
endpackage

// [rtl/usr_flag_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface usr_flag_if;
  logic [usr_pkg::FLAG_W-1:0] set_ev;
  logic [usr_pkg::FLAG_W-1:0] clr;
  logic [usr_pkg::FLAG_W-1:0] flags;
  modport ctrl (output set_ev, output clr, input flags);
  modport store (input set_ev, input clr, output flags);
endinterface
`default_nettype wire

// [rtl/usr_flag_store.sv]
`timescale 1ns/10ps
`default_nettype none
module usr_flag_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event and clear lines
  usr_flag_if.store fi
);
  import usr_pkg::*;

  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Sticky flags, an event beats a clear in the same cycle
  // ----------------------------------------------------------------
  for (genvar i = 0; i < FLAG_W; i++)
  begin : g_flag
    assign flags_next[i] = fi.set_ev[i] | (flags_reg[i] & ~fi.clr[i]);

    a_set_beats_clear: assert property (fi.set_ev[i] |=> flags_reg[i])
      else $error("flag event lost");
    a_clear_ones_only: assert property (
      (!fi.set_ev[i] && fi.clr[i]) |=> !flags_reg[i])
      else $error("flag not cleared");
    a_zero_no_effect: assert property (
      (!fi.set_ev[i] && !fi.clr[i]) |=> $stable(flags_reg[i]))
      else $error("flag changed without cause");
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign fi.flags = flags_reg;
endmodule // usr_flag_store
`default_nettype wire

// [rtl/usr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Status reads pending flags; ones written clear
// - Flag bits: busy, reset, frame, done, endpoints
// - Bit 7 shows DMA busy, raises no interrupt
// - Buffer-set register reports set per endpoint
// - Role bit 7 selects host or peripheral
// - Role bit 6 swaps data line polarity
// - Low frame register holds bits six..zero
// - High frame register holds bits ten..seven
// - DMA count spans low and high bytes
// - High byte write starts DMA when enabled
// - Endpoint three served by DMA only
// - Enable register gates request, keeps flags
// - Control bit 1 enables DMA, 2 direction
module usr_regs (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // Processor port
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic A0,
  input wire logic [usr_pkg::DATA_W-1:0] D_IN,
  output logic [usr_pkg::DATA_W-1:0] D_OUT,
  output logic D_OE_N,
  // Serial engine events
  input wire logic [usr_pkg::EP_COUNT-1:0] EP_DONE,
  input wire logic BUS_RESET_SEEN,
  input wire logic FRAME_START,
  input wire logic [usr_pkg::FRAME_W-1:0] FRAME_NUMBER,
  input wire logic [usr_pkg::EP_COUNT-1:0] BUFFER_SET,
  input wire logic DMA_FINISHED,
  // Control outputs
  output logic INTERRUPT_REQUEST_OUT,
  output logic DMA_START,
  output logic [2*usr_pkg::DATA_W-1:0] DMA_COUNT,
  output logic DMA_DIR_READ,
  output logic DMA_ENABLE,
  output logic USB_ENABLE,
  output logic MASTER_MODE,
  output logic POLARITY_SWAP,
  output logic [usr_pkg::EP_COUNT-1:0] PIO_ENDPOINT_EN
);
  import usr_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  usr_flag_if fl ();

  logic wr_prev_reg;
  logic rd_prev_reg;
  logic [7:0] addr_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] role_reg;
  logic [7:0] frame_lo_reg;
  logic [7:0] frame_hi_reg;
  logic [7:0] cnt_lo_reg;
  logic [7:0] cnt_hi_reg;
  logic [7:0] rdata_reg;
  logic oe_n_reg;
  logic irq_reg;
  logic start_reg;
  logic [EP_COUNT-1:0] pio_en_reg;
  usr_dma_state_type dma_reg;
  usr_dma_state_type dma_next;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  wire wr_act = !CS_N && !WR_N;
  wire rd_act = !CS_N && !RD_N;
  wire wr_take = wr_act && !wr_prev_reg;
  wire rd_take = rd_act && !rd_prev_reg;
  wire addr_wr = wr_take && !A0;
  wire data_wr = wr_take && A0;
  wire wr_ctrl1 = data_wr && hit(addr_reg, OFS_CTRL1);
  wire wr_irq_en = data_wr && hit(addr_reg, OFS_IRQ_ENABLE);
  wire wr_flags = data_wr && hit(addr_reg, OFS_IRQ_FLAGS);
  wire wr_role = data_wr && hit(addr_reg, OFS_ROLE);
  wire wr_cnt_lo = data_wr && hit(addr_reg, OFS_DMA_CNT_LO);
  wire wr_cnt_hi = data_wr && hit(addr_reg, OFS_DMA_CNT_HI);
  // Frame registers are read only, writes fall through to nothing
  wire dma_go = wr_cnt_hi && ctrl1_reg[CTRL1_DMA_EN];
  wire dma_busy = dma_reg == USR_DMA_BUSY;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {dma_busy, fl.flags};
  wire [7:0] bufset_byte = {4'h0, BUFFER_SET};
  wire [7:0] read_data =
    !A0 ? addr_reg :
    hit(addr_reg, OFS_CTRL1) ? ctrl1_reg :
    hit(addr_reg, OFS_IRQ_ENABLE) ? irq_en_reg :
    hit(addr_reg, OFS_IRQ_FLAGS) ? status_byte :
    hit(addr_reg, OFS_BUF_SET) ? bufset_byte :
    hit(addr_reg, OFS_ROLE) ? role_reg :
    hit(addr_reg, OFS_FRAME_LO) ? frame_lo_reg :
    hit(addr_reg, OFS_FRAME_HI) ? frame_hi_reg :
    hit(addr_reg, OFS_DMA_CNT_LO) ? cnt_lo_reg :
    hit(addr_reg, OFS_DMA_CNT_HI) ? cnt_hi_reg :
    8'h00;

  // ----------------------------------------------------------------
  // Flag events and clears
  // ----------------------------------------------------------------
  wire dma_end = dma_busy && DMA_FINISHED && !dma_go;
  assign fl.set_ev = {BUS_RESET_SEEN, FRAME_START, dma_end, EP_DONE};
  assign fl.clr = wr_flags ? D_IN[FLAG_W-1:0] : '0;

  usr_flag_store u_flags (
    .clk(REF_CLK),
    .rst(RESET),
    .fi(fl)
  );

  // Busy bit only, never enters the request term
  wire irq_next = |(fl.flags & irq_en_reg[FLAG_W-1:0]);

  // ----------------------------------------------------------------
  // DMA state
  // ----------------------------------------------------------------
  always_comb
  begin
    dma_next = dma_reg;
    case (dma_reg)
      USR_DMA_IDLE:
      begin
        if (dma_go)
        begin
          dma_next = USR_DMA_BUSY;
        end
      end
      USR_DMA_BUSY:
      begin
        if (DMA_FINISHED && !dma_go)
        begin
          dma_next = USR_DMA_IDLE;
        end
      end
      default:
      begin
        dma_next = USR_DMA_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      addr_reg <= ADDR_RESET;
      dma_reg <= USR_DMA_IDLE;
    end
    else
    begin
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
      if (addr_wr)
      begin
        addr_reg <= D_IN;
      end
      dma_reg <= dma_next;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl1_reg <= CTRL1_RESET;
      irq_en_reg <= IRQ_ENABLE_RESET;
      role_reg <= ROLE_RESET;
    end
    else
    begin
      if (wr_ctrl1)
      begin
        ctrl1_reg <= D_IN;
      end
      if (wr_irq_en)
      begin
        irq_en_reg <= D_IN;
      end
      if (wr_role)
      begin
        role_reg <= {D_IN[ROLE_MASTER], D_IN[ROLE_SWAP], 6'h00};
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      frame_lo_reg <= FRAME_RESET;
      frame_hi_reg <= FRAME_RESET;
      cnt_lo_reg <= DMA_CNT_RESET;
      cnt_hi_reg <= DMA_CNT_RESET;
    end
    else
    begin
      if (FRAME_START)
      begin
        frame_lo_reg <= {FRAME_NUMBER[FRAME_LO_W-1:0], 1'b0};
        frame_hi_reg <= {FRAME_NUMBER[FRAME_W-1:FRAME_LO_W], 4'h0};
      end
      if (wr_cnt_lo)
      begin
        cnt_lo_reg <= D_IN;
      end
      if (wr_cnt_hi)
      begin
        cnt_hi_reg <= D_IN;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      rdata_reg <= 8'h00;
      oe_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      start_reg <= 1'b0;
      pio_en_reg <= '0;
    end
    else
    begin
      if (rd_take)
      begin
        rdata_reg <= read_data;
      end
      oe_n_reg <= !rd_act;
      irq_reg <= irq_next;
      start_reg <= dma_go;
      // Endpoint three never gets port service
      pio_en_reg <= {1'b0, {(EP_COUNT-1){ctrl1_reg[CTRL1_USB_EN]}}};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign D_OUT = rdata_reg;
  assign D_OE_N = oe_n_reg;
  assign INTERRUPT_REQUEST_OUT = irq_reg;
  assign DMA_START = start_reg;
  assign DMA_COUNT = {cnt_hi_reg, cnt_lo_reg};
  assign DMA_DIR_READ = ctrl1_reg[CTRL1_DMA_DIR];
  assign DMA_ENABLE = ctrl1_reg[CTRL1_DMA_EN];
  assign USB_ENABLE = ctrl1_reg[CTRL1_USB_EN];
  assign MASTER_MODE = role_reg[ROLE_MASTER];
  assign POLARITY_SWAP = role_reg[ROLE_SWAP];
  assign PIO_ENDPOINT_EN = pio_en_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_high_write_enabled;
    wr_cnt_hi && ctrl1_reg[CTRL1_DMA_EN];
  endsequence

  sequence s_start_then_busy;
    DMA_START && dma_busy;
  endsequence

  a_status_read: assert property (
    (rd_take && A0 && hit(addr_reg, OFS_IRQ_FLAGS)) |=> D_OUT == $past(status_byte))
    else $error("status read wrong");
  a_busy_bit: assert property (
    (rd_take && A0 && hit(addr_reg, OFS_IRQ_FLAGS)) |=> D_OUT[BIT_DMA_BUSY] == $past(dma_busy))
    else $error("busy bit wrong");
  a_busy_no_irq: assert property (
    1'b1 |=> INTERRUPT_REQUEST_OUT == $past(|(fl.flags & irq_en_reg[FLAG_W-1:0])))
    else $error("request mismatch");
  a_bufset_read: assert property (
    (rd_take && A0 && hit(addr_reg, OFS_BUF_SET)) |=> D_OUT == {4'h0, $past(BUFFER_SET)})
    else $error("buffer set read wrong");
  a_role_write: assert property (
    wr_role |=> MASTER_MODE == $past(D_IN[ROLE_MASTER])
      && POLARITY_SWAP == $past(D_IN[ROLE_SWAP]))
    else $error("role bits not taken");
  a_frame_capture: assert property (
    FRAME_START |=> frame_lo_reg[7:1] == $past(FRAME_NUMBER[6:0])
      && frame_hi_reg[7:4] == $past(FRAME_NUMBER[10:7]))
    else $error("frame number not captured");
  a_dma_start: assert property (s_high_write_enabled |=> s_start_then_busy)
    else $error("DMA did not start");
  a_no_start_off: assert property (DMA_START |-> $past(dma_go))
    else $error("spurious DMA start");
  a_count_pair: assert property (
    wr_cnt_hi |=> DMA_COUNT[15:8] == $past(D_IN) && $stable(DMA_COUNT[7:0]))
    else $error("count high byte wrong");
  a_ep3_dma_only: assert property (!PIO_ENDPOINT_EN[ENDPOINT_THREE])
    else $error("endpoint three given port service");
  a_enable_keeps: assert property (
    (wr_irq_en && !wr_flags && fl.set_ev == '0) |=> $stable(fl.flags))
    else $error("enable write touched flags");
  a_dma_ctrl: assert property (
    wr_ctrl1 |=> DMA_ENABLE == $past(D_IN[CTRL1_DMA_EN])
      && DMA_DIR_READ == $past(D_IN[CTRL1_DMA_DIR]))
    else $error("DMA control bits wrong");
endmodule // usr_regs
`default_nettype wire

// [testbench/usr_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
module usr_cpu_model (
  // Clock
  input wire logic clk,
  // Processor strobes and data
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic a0,
  output logic [7:0] dq
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    a0 = 1'b0;
    dq = 8'h00;
  end
  // One strobe per access; released data shows its inverse
  task automatic access(input logic rd, input logic a, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= ~rd;
    wr_n <= rd;
    a0 <= a;
    dq <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    dq <= ~d;
    @(posedge clk);
  endtask
  // Index then data; frame registers are never written
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    access(1'b0, 1'b0, ofs);
    access(1'b0, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] ofs);
    access(1'b0, 1'b0, ofs);
    access(1'b1, 1'b1, 8'h00);
  endtask
  // Low count byte always before the high byte
  task automatic dma_count(input logic [15:0] cnt);
    wr(usr_pkg::OFS_DMA_CNT_LO, cnt[7:0]);
    wr(usr_pkg::OFS_DMA_CNT_HI, cnt[15:8]);
  endtask
endmodule // usr_cpu_model
`default_nettype wire

// [testbench/usr_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module usr_regs_tb_top;
  import usr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, rd_n, wr_n, a0, d_oe_n, irq, dma_start, dma_dir, dma_en, usb_en, master, swap;
  logic [7:0] d_in, d_out, r8;
  logic [15:0] dma_cnt;
  logic [3:0] ep_done = 4'h0;
  logic [3:0] buf_set = 4'h0;
  logic [3:0] pio_en;
  logic bus_rst = 1'b0;
  logic frame_start = 1'b0;
  logic dma_fin = 1'b0;
  logic oe_prev = 1'b1;
  logic [10:0] fn = 11'h000;
  logic [7:0] exp_q[$];
  logic [7:0] seed_vals[3] = '{8'hFF, 8'h40, 8'h80};
  int error_cnt = 0;
  int n_checks = 0;
  int starts = 0;
  int seed = 84;
  always #12.5 ref_clk = ~ref_clk;
  usr_cpu_model u_cpu (.clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .dq(d_in));
  usr_regs DUT (.REF_CLK(ref_clk), .RESET(reset), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .A0(a0), .D_IN(d_in), .D_OUT(d_out), .D_OE_N(d_oe_n), .EP_DONE(ep_done),
    .BUS_RESET_SEEN(bus_rst), .FRAME_START(frame_start), .FRAME_NUMBER(fn),
    .BUFFER_SET(buf_set), .DMA_FINISHED(dma_fin), .INTERRUPT_REQUEST_OUT(irq),
    .DMA_START(dma_start), .DMA_COUNT(dma_cnt), .DMA_DIR_READ(dma_dir), .DMA_ENABLE(dma_en),
    .USB_ENABLE(usb_en), .MASTER_MODE(master), .POLARITY_SWAP(swap), .PIO_ENDPOINT_EN(pio_en));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read results are compared by the watcher below
  task automatic rd_exp(input logic [7:0] ofs, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_cpu.rd(ofs);
  endtask
  task automatic pulse(input logic [3:0] ep, input logic br, input logic fs, input logic df);
    @(posedge ref_clk);
    ep_done <= ep;
    bus_rst <= br;
    frame_start <= fs;
    dma_fin <= df;
    @(posedge ref_clk);
    ep_done <= 4'h0;
    bus_rst <= 1'b0;
    frame_start <= 1'b0;
    dma_fin <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  always @(posedge ref_clk)
  begin
    oe_prev <= d_oe_n;
    if (dma_start === 1'b1)
      starts++;
    if (d_oe_n === 1'b0 && oe_prev === 1'b1)
      check({8'h00, d_out}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hxxxx);
  end
  initial
  begin
    #500_000;
    error_cnt++;
    $display("watchdog expired");
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    // Reset values and an unmapped index
    rd_exp(OFS_CTRL1, 8'h00);
    rd_exp(OFS_IRQ_ENABLE, 8'h00);
    rd_exp(OFS_IRQ_FLAGS, 8'h00);
    rd_exp(OFS_ROLE, 8'h00);
    rd_exp(OFS_DMA_CNT_HI, 8'h00);
    rd_exp(8'h20, 8'h00);
    $display("test reset done");
    // Every event flag but DMA done, frame capture, write-one clearing, request
    fn <= 11'($random(seed));
    pulse(4'hF, 1'b1, 1'b1, 1'b0);
    rd_exp(OFS_IRQ_FLAGS, 8'h6F);
    rd_exp(OFS_FRAME_LO, {fn[6:0], 1'b0});
    rd_exp(OFS_FRAME_HI, {fn[10:7], 4'h0});
    u_cpu.wr(OFS_IRQ_FLAGS, 8'h05);
    rd_exp(OFS_IRQ_FLAGS, 8'h6A);
    u_cpu.wr(OFS_IRQ_ENABLE, 8'h02);
    settle();
    check(irq, 1'b1);
    rd_exp(OFS_IRQ_FLAGS, 8'h6A);
    u_cpu.wr(OFS_IRQ_FLAGS, 8'h02);
    settle();
    check(irq, 1'b0);
    u_cpu.wr(OFS_IRQ_FLAGS, 8'hFF);
    rd_exp(OFS_IRQ_FLAGS, 8'h00);
    $display("test flags done");
    // Buffer set is live and read only
    repeat (4)
    begin
      r8 = 8'($random(seed));
      buf_set <= r8[3:0];
      u_cpu.wr(OFS_BUF_SET, ~r8);
      rd_exp(OFS_BUF_SET, {4'h0, r8[3:0]});
    end
    $display("test buffer set done");
    // Role and polarity bits, reserved bits read zero
    foreach (seed_vals[i])
    begin
      u_cpu.wr(OFS_ROLE, seed_vals[i]);
      rd_exp(OFS_ROLE, seed_vals[i] & 8'hC0);
      check({master, swap}, seed_vals[i][7:6]);
    end
    $display("test role done");
    // Count stored while DMA is disabled, no start
    u_cpu.wr(OFS_CTRL1, 8'h00);
    r8 = 8'($random(seed));
    u_cpu.dma_count({r8, ~r8});
    check(dma_cnt, {r8, ~r8});
    check(starts, 0);
    rd_exp(OFS_IRQ_FLAGS, 8'h00);
    // Enabled DMA, high byte 00h, busy raises no request
    u_cpu.wr(OFS_CTRL1, 8'h03);
    check({dma_dir, dma_en, usb_en}, 3'b011);
    u_cpu.wr(OFS_CTRL1, 8'h07);
    u_cpu.wr(OFS_IRQ_ENABLE, 8'h80);
    check({dma_dir, dma_en, usb_en}, 3'b111);
    check(pio_en, 4'h7);
    u_cpu.dma_count({8'h00, r8});
    // Let the start pulse be counted before looking
    settle();
    check(starts, 1);
    rd_exp(OFS_IRQ_FLAGS, 8'h80);
    check(irq, 1'b0);
    pulse(4'h0, 1'b0, 1'b0, 1'b1);
    // Completion with only the busy enable set raises nothing
    check(irq, 1'b0);
    rd_exp(OFS_IRQ_FLAGS, 8'h10);
    u_cpu.wr(OFS_IRQ_ENABLE, 8'h10);
    settle();
    check(irq, 1'b1);
    $display("test dma done");
    repeat (3) @(posedge ref_clk);
    check(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule // usr_regs_tb_top
`default_nettype wire
